/* File: bjc_pkg.sv */
// Package of constants and types for the branch and jump control block
`default_nettype none
package bjc_pkg;
    // ------------------------------------------------------------
    // Widths and field positions
    // ------------------------------------------------------------
    localparam int XLEN = 64;              // Register and address width
    localparam int DISP_W = 21;            // Branch displacement field width
    localparam int JDISP_W = 16;           // Jump displacement field width
    localparam int HINT_MSB = 15;          // Jump hint type upper bit
    localparam int HINT_LSB = 14;          // Jump hint type lower bit
    localparam int HOP_W = 14;             // Jump hint operand width
    localparam int PRED_W = 16;            // Predicted target low bits
    localparam int RIDX_W = 5;             // Register index width
    localparam int INSN_SHIFT = 2;         // Longword scaling of offsets
    localparam int RAS_DEPTH = 8;          // Return stack entries
    localparam logic [1:0] ALIGN_MASK = 2'h3; // Low bits cleared on jumps

    // ------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BJC_OP_NONE = 2'b00,               // Not a control transfer
        BJC_OP_COND = 2'b01,               // Conditional branch
        BJC_OP_UNCOND = 2'b10,             // Plain or call branch
        BJC_OP_JUMP = 2'b11                // Register indirect jump
    } bjc_op_t;

    typedef enum logic [2:0] {
        BJC_C_ZERO = 3'b000,               // branch_if_zero
        BJC_C_NONZERO = 3'b001,            // branch_if_nonzero
        BJC_C_NEG = 3'b010,                // branch_if_negative
        BJC_C_NONPOS = 3'b011,             // branch_if_nonpositive
        BJC_C_POS = 3'b100,                // branch_if_positive
        BJC_C_NONNEG = 3'b101,             // branch_if_nonnegative
        BJC_C_LBC = 3'b110,                // branch_if_low_bit_clear
        BJC_C_LBS = 3'b111                 // branch_if_low_bit_set
    } bjc_cond_t;

    typedef enum logic [1:0] {
        BJC_H_PLAIN = 2'b00,               // plain_jump
        BJC_H_CALL = 2'b01,                // call_jump
        BJC_H_RETURN = 2'b10,              // return_jump
        BJC_H_COROUTINE = 2'b11            // coroutine_jump
    } bjc_hint_t;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;                        // Instruction present
        bjc_op_t op;                        // Transfer class
        bjc_cond_t cond;                    // Conditional test
        logic call;                         // Branch is call_branch
        logic [DISP_W-1:0] disp;            // Branch displacement
        logic [JDISP_W-1:0] jdisp;          // Jump hint field
        logic [RIDX_W-1:0] link_or_test_reg; // Link or test register
        logic [XLEN-1:0] pc_upd;            // Updated PC
        logic [XLEN-1:0] test_val;          // Test register value
        logic [XLEN-1:0] base_val;          // Base register value
        logic [XLEN-1:0] fetch_next;        // Address fetch went to next
    } bjc_req_t;

    typedef struct packed {
        logic valid;                        // Result present
        logic taken;                        // Transfer taken
        logic [XLEN-1:0] next_pc;           // Resolved next PC
        logic link_we;                      // Link write enable
        logic [RIDX_W-1:0] link_idx;        // Link register index
        logic [XLEN-1:0] link_val;          // Link value
        logic flush;                        // Wrong path discarded
    } bjc_res_t;

    typedef struct packed {
        logic valid;                        // Hint present
        logic dir_taken;                    // Static direction hint
        logic tgt_valid;                    // Low target bits meaningful
        logic [PRED_W-1:0] tgt_lo;          // Predicted low target bits
        logic ras_push;                     // Stack push made
        logic ras_pop;                      // Stack pop made
    } bjc_hint_out_t;
endpackage
`default_nettype wire

/* File: bjc_ras.sv */
// Return-address prediction stack with registered top of stack
`timescale 1ns/1ps
`default_nettype none
module bjc_ras
    import bjc_pkg::*;
#(
    parameter int DEPTH = RAS_DEPTH,
    parameter int WIDTH = PRED_W
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic push,
    input wire logic pop,
    input wire logic [WIDTH-1:0] push_val,
    output logic [WIDTH-1:0] top_q
);
    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("bjc_ras depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];      // Circular entry storage
    logic [PW-1:0] ptr_q;                 // Index of current top
    logic [PW-1:0] ptr_dn;                // Index below the top
    logic [PW-1:0] ptr_up;                // Index above the top

    assign ptr_dn = ptr_q - 1'b1;
    assign ptr_up = ptr_q + 1'b1;

    // ------------------------------------------------------------
    // Pointer: circular, so overflow overwrites the oldest entry
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ptr_q <= '0;
        end else if (push && !pop) begin
            ptr_q <= ptr_up;
        end else if (pop && !push) begin
            ptr_q <= ptr_dn;
        end
    end

    // Storage: pop then push replaces the top in place; cleared at
    // reset so an underflow pop reads zero or a stale entry, never an unknown one
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mem_q <= '{default: '0};
        end else if (push && pop) begin
            mem_q[ptr_q] <= push_val;
        end else if (push) begin
            mem_q[ptr_up] <= push_val;
        end
    end

    // Registered top, kept in step with the pointer
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            top_q <= '0;
        end else if (push) begin
            top_q <= push_val;
        end else if (pop) begin
            top_q <= mem_q[ptr_dn];
        end
    end
endmodule // bjc_ras
`default_nettype wire

/* File: bjc_branch_ctrl.sv */
// Branch and jump resolution with static prediction hints
`timescale 1ns/1ps
`default_nettype none
module bjc_branch_ctrl
    import bjc_pkg::*;
#(
    parameter int STACK_DEPTH = RAS_DEPTH   // Return stack entries
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire bjc_req_t req,
    output bjc_res_t res_q,
    output bjc_hint_out_t hint_q,
    output logic [XLEN-1:0] redirect_pc_q,
    output logic redirect_q
);
    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (STACK_DEPTH < 2) begin : g_bad_stack
        $error("bjc_branch_ctrl needs a return stack of at least 2");
    end
    if (JDISP_W != HOP_W + 2 || PRED_W > XLEN) begin : g_bad_fields
        $error("bjc_branch_ctrl hint field layout is inconsistent");
    end

    // ------------------------------------------------------------
    // Decode of the request
    // ------------------------------------------------------------
    logic is_cond;                          // Conditional branch
    logic is_uncond;                        // Plain or call branch
    logic is_jump;                          // Register indirect jump
    bjc_hint_t hint_type;                   // Jump hint type field
    logic [HOP_W-1:0] hint_op;              // Jump hint operand

    assign is_cond = req.valid && (req.op == BJC_OP_COND);
    assign is_uncond = req.valid && (req.op == BJC_OP_UNCOND);
    assign is_jump = req.valid && (req.op == BJC_OP_JUMP);
    // Type bits only matter to prediction, never to execution
    assign hint_type = bjc_hint_t'(req.jdisp[HINT_MSB:HINT_LSB]);
    assign hint_op = req.jdisp[HOP_W-1:0];

    // ------------------------------------------------------------
    // Branch target arithmetic
    // ------------------------------------------------------------
    logic [XLEN-1:0] disp_sext;             // Displacement widened
    logic [XLEN-1:0] br_offset;             // Byte offset
    logic [XLEN-1:0] br_target;             // PC-relative target

    // Sign extension covers the full 21-bit field: +/- 1M insns
    assign disp_sext = {{(XLEN-DISP_W){req.disp[DISP_W-1]}}, req.disp};
    // Shift drops the two top bits, which equal the sign anyway
    assign br_offset = {disp_sext[XLEN-1-INSN_SHIFT:0], {INSN_SHIFT{1'b0}}};
    // Always relative to the updated PC, never the branch's own
    assign br_target = req.pc_upd + br_offset;

    // ------------------------------------------------------------
    // Condition evaluation
    // ------------------------------------------------------------
    logic tv_zero;                          // Test value is zero
    logic tv_neg;                           // Test value is negative
    logic cond_true;                        // Selected test holds

    // All 64 bits take part; no narrower compare is allowed
    assign tv_zero = (req.test_val == '0);
    assign tv_neg = req.test_val[XLEN-1];

    // Eight tests picked by the opcode
    always_comb begin
        case (req.cond)
            BJC_C_ZERO: cond_true = tv_zero;
            BJC_C_NONZERO: cond_true = !tv_zero;
            BJC_C_NEG: cond_true = tv_neg;
            BJC_C_NONPOS: cond_true = tv_neg || tv_zero;
            BJC_C_POS: cond_true = !tv_neg && !tv_zero;
            BJC_C_NONNEG: cond_true = !tv_neg;
            BJC_C_LBC: cond_true = !req.test_val[0];
            BJC_C_LBS: cond_true = req.test_val[0];
            default: cond_true = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Jump target
    // ------------------------------------------------------------
    logic [XLEN-1:0] jmp_target;            // Aligned base value

    // Base value is the operand read before any link write lands,
    // so a shared link and base register still sees the old value
    assign jmp_target = {req.base_val[XLEN-1:2], req.base_val[1:0] & ~ALIGN_MASK};

    // ------------------------------------------------------------
    // Architectural resolution (hint bits have no say here)
    // ------------------------------------------------------------
    logic taken_d;                          // Transfer is taken
    logic [XLEN-1:0] next_pc_d;             // Resolved next PC
    logic link_we_d;                        // Link write wanted

    always_comb begin
        taken_d = 1'b0;
        next_pc_d = req.pc_upd;
        link_we_d = 1'b0;
        if (is_cond) begin
            // Conditional branches have no link; fall through on false
            taken_d = cond_true;
            next_pc_d = cond_true ? br_target : req.pc_upd;
        end else if (is_uncond) begin
            // Call and plain branch resolve exactly alike
            taken_d = 1'b1;
            next_pc_d = br_target;
            link_we_d = 1'b1;
        end else if (is_jump) begin
            // All four jump types behave the same; hint ignored
            taken_d = 1'b1;
            next_pc_d = jmp_target;
            link_we_d = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Prediction hints
    // ------------------------------------------------------------
    logic ras_push_d;                       // Push updated PC
    logic ras_pop_d;                        // Pop the stack
    logic dir_d;                            // Static direction
    logic tgt_valid_d;                      // Low target meaningful
    logic [PRED_W-1:0] tgt_lo_d;            // Predicted low bits
    logic [PRED_W-1:0] jhint_tgt;           // Jump operand target
    logic [PRED_W-1:0] ras_top;             // Stack top, registered

    // Same arithmetic as a PC-relative branch, low bits only
    assign jhint_tgt = req.pc_upd[PRED_W-1:0] + {hint_op, {INSN_SHIFT{1'b0}}};

    // Stack actions, direction and likely target per transfer
    always_comb begin
        ras_push_d = 1'b0;
        ras_pop_d = 1'b0;
        dir_d = 1'b0;
        tgt_valid_d = 1'b0;
        tgt_lo_d = '0;
        if (is_cond) begin
            // Backward means loop, so guess taken; stack untouched
            dir_d = req.disp[DISP_W-1];
            tgt_valid_d = 1'b1;
            tgt_lo_d = br_target[PRED_W-1:0];
        end else if (is_uncond) begin
            dir_d = 1'b1;
            tgt_valid_d = 1'b1;
            tgt_lo_d = br_target[PRED_W-1:0];
            ras_push_d = req.call;
        end else if (is_jump) begin
            dir_d = 1'b1;
            tgt_valid_d = 1'b1;
            case (hint_type)
                BJC_H_PLAIN: begin
                    tgt_lo_d = jhint_tgt;
                end
                BJC_H_CALL: begin
                    tgt_lo_d = jhint_tgt;
                    ras_push_d = 1'b1;
                end
                BJC_H_RETURN: begin
                    // Operand bits are reserved; only the stack feeds it
                    tgt_lo_d = ras_top;
                    ras_pop_d = 1'b1;
                end
                BJC_H_COROUTINE: begin
                    tgt_lo_d = ras_top;
                    ras_pop_d = 1'b1;
                    ras_push_d = 1'b1;
                end
                default: begin
                    tgt_valid_d = 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Return-address stack
    // ------------------------------------------------------------
    // Only the low bits are kept: enough to start an early cache
    // access, at a fraction of the storage of full addresses
    bjc_ras #(
        .DEPTH(STACK_DEPTH),
        .WIDTH(PRED_W)
    ) u_ras (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .push(ras_push_d),
        .pop(ras_pop_d),
        .push_val(req.pc_upd[PRED_W-1:0]),
        .top_q(ras_top)
    );

    // ------------------------------------------------------------
    // Misprediction detection
    // ------------------------------------------------------------
    logic mispredict_d;                     // Fetch went elsewhere

    // Any instruction the fetch unit issued behind this one is
    // wrong-path when the resolved address differs from its guess
    assign mispredict_d = req.valid && (req.op != BJC_OP_NONE)
                          && (next_pc_d != req.fetch_next);

    // ------------------------------------------------------------
    // Result register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            res_q <= '0;
        end else begin
            res_q.valid <= is_cond || is_uncond || is_jump;
            res_q.taken <= taken_d;
            res_q.next_pc <= next_pc_d;
            res_q.link_we <= link_we_d;
            res_q.link_idx <= req.link_or_test_reg;
            res_q.link_val <= req.pc_upd;
            res_q.flush <= mispredict_d;
        end
    end

    // ------------------------------------------------------------
    // Hint register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            hint_q <= '0;
        end else begin
            hint_q.valid <= is_cond || is_uncond || is_jump;
            hint_q.dir_taken <= dir_d;
            hint_q.tgt_valid <= tgt_valid_d;
            hint_q.tgt_lo <= tgt_lo_d;
            hint_q.ras_push <= ras_push_d;
            hint_q.ras_pop <= ras_pop_d;
        end
    end

    // ------------------------------------------------------------
    // Fetch redirect
    // ------------------------------------------------------------
    // Redirect carries the resolved address so wrong-path work is
    // dropped and fetch restarts there; both are registered, one cycle after the request
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            redirect_q <= 1'b0;
            redirect_pc_q <= '0;
        end else begin
            redirect_q <= mispredict_d;
            if (mispredict_d) begin
                redirect_pc_q <= next_pc_d;
            end
        end
    end
endmodule // bjc_branch_ctrl
`default_nettype wire

/* File: bjc_branch_ctrl_props.sv */
// Checker of the branch and jump control block port behaviour
`timescale 1ns/1ps
`default_nettype none
module bjc_chk
    import bjc_pkg::*;
#(
    parameter int STACK_DEPTH = RAS_DEPTH // Return stack entries
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire bjc_req_t req,
    input wire bjc_res_t res_q,
    input wire bjc_hint_out_t hint_q,
    input wire logic [XLEN-1:0] redirect_pc_q,
    input wire logic redirect_q
);
    // ------------------------------------------------
    // Decoded request helpers
    // ------------------------------------------------
    logic act; // Control transfer presented
    logic is_c; // Conditional branch presented
    logic is_u; // Plain or call branch presented
    logic is_j; // Register jump presented
    logic [XLEN-1:0] tgt; // PC-relative target
    logic [1:0] ht; // Jump hint type
    assign act = req.valid && (req.op != BJC_OP_NONE);
    assign is_c = act && (req.op == BJC_OP_COND);
    assign is_u = act && (req.op == BJC_OP_UNCOND);
    assign is_j = act && (req.op == BJC_OP_JUMP);
    assign tgt = req.pc_upd + {{41{req.disp[20]}}, req.disp, 2'b00};
    assign ht = req.jdisp[15:14];
    // One clock domain, so clock and reset are given once
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // ------------------------------------------------
    // Properties
    // ------------------------------------------------
    idle_quiet_a:
        assert property (!act |=> !res_q.valid && !redirect_q) else $error("Pulse without request");
    cond_target_a:
        assert property (is_c |=> res_q.next_pc == (res_q.taken ? $past(tgt) : $past(req.pc_upd)))
        else $error("Conditional next PC wrong");
    cond_no_stack_a:
        assert property (is_c |=> !hint_q.ras_push && !hint_q.ras_pop && !res_q.link_we)
        else $error("Conditional touched stack or link");
    dir_hint_a:
        assert property (is_c |=> hint_q.dir_taken == $past(req.disp[20])) else $error("Direction hint wrong");
    uncond_target_a:
        assert property (is_u |=> res_q.taken && res_q.next_pc == $past(tgt)) else $error("Branch target wrong");
    link_value_a:
        assert property ((is_u || is_j) |=> res_q.link_we && res_q.link_val == $past(req.pc_upd)
            && res_q.link_idx == $past(req.link_or_test_reg)) else $error("Link write wrong");
    jump_target_a:
        assert property (is_j |=> res_q.next_pc == {$past(req.base_val[63:2]), 2'b00})
        else $error("Jump target wrong");
    branch_push_a:
        assert property (is_u |=> hint_q.ras_push == $past(req.call) && !hint_q.ras_pop)
        else $error("Branch stack action wrong");
    jump_stack_a:
        assert property (is_j |=> {hint_q.ras_push, hint_q.ras_pop} == $past({ht[0], ht[1]}))
        else $error("Jump stack action wrong");
    hint_target_a:
        assert property (is_j && !ht[1] |=> hint_q.tgt_lo == $past(req.pc_upd[15:0]
            + {req.jdisp[13:0], 2'b00})) else $error("Jump hint target wrong");
    redirect_match_a:
        assert property (act |=> redirect_q == (res_q.next_pc != $past(req.fetch_next))
            && (!redirect_q || redirect_pc_q == res_q.next_pc)) else $error("Redirect wrong");
endmodule // bjc_chk
bind bjc_branch_ctrl bjc_chk #(.STACK_DEPTH(STACK_DEPTH)) u_chk (.clk_sys(clk_sys),
    .reset_n(reset_n), .req(req), .res_q(res_q), .hint_q(hint_q),
    .redirect_pc_q(redirect_pc_q), .redirect_q(redirect_q));
`default_nettype wire

/* File: tb_top.sv */
// Self-checking testbench of the branch and jump control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import bjc_pkg::*;
    // ------------------------------------------------
    // Clock, reset, state of the bench
    // ------------------------------------------------
    logic clk_sys = 1'b0; // 40 MHz clock
    logic reset_n = 1'b0; // Held low at start
    bjc_req_t req = '0; // Driven at falling edge
    bjc_req_t r; // Request being built
    bjc_res_t res_q;
    bjc_hint_out_t hint_q;
    logic [XLEN-1:0] redirect_pc_q;
    logic redirect_q;
    int fails = 0;
    int n_checks = 0;
    int seed = 57364; // Fixed seed keeps runs repeatable
    logic [15:0] stk [8] = '{default: 16'h0}; // Mirror of return stack
    logic [2:0] sp = 3'h0; // Mirror stack pointer, wraps
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    bjc_branch_ctrl #(.STACK_DEPTH(8)) dut (.clk_sys(clk_sys), .reset_n(reset_n), .req(req),
        .res_q(res_q), .hint_q(hint_q), .redirect_pc_q(redirect_pc_q), .redirect_q(redirect_q));
    // ------------------------------------------------
    // Expectation functions and compare tasks
    // ------------------------------------------------
    function automatic logic cond_true(bjc_cond_t c, logic [63:0] v);
        case (c)
            BJC_C_ZERO: return v == 64'h0;
            BJC_C_NONZERO: return v != 64'h0;
            BJC_C_NEG: return $signed(v) < 0;
            BJC_C_NONPOS: return $signed(v) <= 0;
            BJC_C_POS: return $signed(v) > 0;
            BJC_C_NONNEG: return $signed(v) >= 0;
            BJC_C_LBC: return !v[0];
            default: return v[0];
        endcase
    endfunction
    function automatic logic [63:0] br_tgt(bjc_req_t q);
        return q.pc_upd + {{41{q.disp[20]}}, q.disp, 2'b00};
    endfunction
    // Random request with corner test values mixed in
    function automatic bjc_req_t rnd_req(bjc_op_t op);
        bjc_req_t q;
        q.valid = 1'b1;
        q.op = op;
        q.cond = bjc_cond_t'(3'($random(seed)));
        q.call = 1'($random(seed));
        q.disp = 21'($random(seed));
        q.jdisp = 16'($random(seed));
        q.link_or_test_reg = 5'($random(seed));
        q.pc_upd = {$random(seed), $random(seed)} & 64'hFFFF_FFFF_FFFF_FFFC;
        q.base_val = {$random(seed), $random(seed)};
        q.test_val = {$random(seed), $random(seed)};
        case (3'($random(seed)))
            3'h0: q.test_val = 64'h0;
            3'h1: q.test_val = 64'hFFFF_FFFF_FFFF_FFFF;
            3'h2: q.test_val = 64'h1;
            3'h3: q.test_val = 64'h8000_0000_0000_0000;
            default: ;
        endcase
        // Fetch guess either right or wrong, so both outcomes occur
        q.fetch_next = q.pc_upd;
        if ($random(seed) & 1) q.fetch_next = op == BJC_OP_JUMP ? {q.base_val[63:2], 2'b00} : br_tgt(q);
        return q;
    endfunction
    task automatic chk_val(input string n, input logic [63:0] e, input logic [63:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_bit(input string n, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %b seen %b", n, e, g);
        end
    endtask
    // Present one request, then check its answer one cycle later
    task automatic send(input bjc_req_t q);
        logic act, tk, fl, ps, pp;
        logic [63:0] nx, bt;
        logic [15:0] tl;
        req = q;
        act = q.valid && q.op != BJC_OP_NONE;
        bt = br_tgt(q);
        tk = q.op == BJC_OP_COND ? cond_true(q.cond, q.test_val) : 1'b1;
        nx = q.op == BJC_OP_JUMP ? {q.base_val[63:2], 2'b00} : (tk ? bt : q.pc_upd);
        fl = nx != q.fetch_next;
        tl = q.jdisp[15] ? stk[sp] : q.pc_upd[15:0] + {q.jdisp[13:0], 2'b00};
        ps = act && (q.op == BJC_OP_UNCOND ? q.call : q.op == BJC_OP_JUMP && q.jdisp[14]);
        pp = act && q.op == BJC_OP_JUMP && q.jdisp[15];
        // Coroutine pops then pushes, replacing the top
        if (pp) sp = sp - 3'h1;
        if (ps) begin
            sp = sp + 3'h1;
            stk[sp] = q.pc_upd[15:0];
        end
        @(negedge clk_sys);
        chk_bit("valid", act, res_q.valid);
        chk_bit("hint_valid", act, hint_q.valid);
        chk_bit("redirect", act && fl, redirect_q);
        if (act) begin
            chk_bit("taken", tk, res_q.taken);
            chk_val("next_pc", nx, res_q.next_pc);
            chk_bit("flush", fl, res_q.flush);
            if (fl) chk_val("redirect_pc", nx, redirect_pc_q);
            chk_bit("link_we", q.op != BJC_OP_COND, res_q.link_we);
            if (q.op != BJC_OP_COND) chk_val("link_val", q.pc_upd, res_q.link_val);
            chk_bit("push", ps, hint_q.ras_push);
            chk_bit("pop", pp, hint_q.ras_pop);
            chk_bit("tgt_valid", 1'b1, hint_q.tgt_valid);
            chk_bit("dir", q.op == BJC_OP_COND ? q.disp[20] : 1'b1, hint_q.dir_taken);
            if (q.op != BJC_OP_JUMP) chk_val("cond_hint", bt[15:0], hint_q.tgt_lo);
            if (q.op == BJC_OP_JUMP) chk_val("jump_hint", tl, hint_q.tgt_lo);
        end
    endtask
    task automatic print_verdict();
        $display("Checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        repeat (2) @(negedge clk_sys);
        reset_n = 1'b1;
        chk_bit("reset_valid", 1'b0, res_q.valid);
        // Every test code, back to back
        for (int i = 0; i < 32; i++) begin
            r = rnd_req(BJC_OP_COND);
            r.cond = bjc_cond_t'(i[2:0]);
            send(r);
        end
        // Plain and call branches at displacement extremes
        for (int i = 0; i < 8; i++) begin
            r = rnd_req(BJC_OP_UNCOND);
            r.call = i[0];
            if (i[2:1] == 2'h1) r.disp = 21'h100000;
            if (i[2:1] == 2'h2) r.disp = 21'h0FFFFF;
            if (i[2:1] == 2'h3) r.disp = 21'h000000;
            send(r);
        end
        // Jump types in order: call then return back to back
        for (int i = 0; i < 16; i++) begin
            r = rnd_req(BJC_OP_JUMP);
            r.jdisp[15:14] = i[1:0];
            send(r);
        end
        // Random mix with idle and invalid slots
        for (int i = 0; i < 300; i++) begin
            r = rnd_req(bjc_op_t'(2'($random(seed))));
            r.valid = 3'($random(seed)) != 3'h0;
            send(r);
        end
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
